// *** rtl/sfp_pkg.sv ***
// shared constants, types and helpers of the serial flash protect gate
package sfp_pkg;
   // opcodes taken from the command table
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS   = 8'h05;
   localparam logic [7:0] OP_READ_CONFIG   = 8'h15;
   localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
   localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
   localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] OP_READ          = 8'h03;
   localparam logic [7:0] OP_FAST_READ     = 8'h0B;
   // otp and security opcodes: values arbitrary
   localparam logic [7:0] OP_ENTER_OTP     = 8'hA1;
   localparam logic [7:0] OP_EXIT_OTP      = 8'hA2;
   localparam logic [7:0] OP_SEC_READ      = 8'hA3;
   localparam logic [7:0] OP_SEC_WRITE     = 8'hA4;

   // field positions in status, config and security bytes, and in the address
   localparam int STS_BUSY_POS   = 0;
   localparam int STS_WEL_POS    = 1;
   localparam int STS_LEVEL_LSB  = 2;
   localparam int STS_STATUS_WRITE_DISABLE_POS   = 7;
   localparam int CFG_BOTTOM_POS = 3;
   localparam int SEC_FACT_POS   = 0;
   localparam int SEC_CUST_POS   = 1;
   localparam int OTP_HALF_POS   = 9;
   localparam int BLOCK_LSB      = 16;

   // least frame lengths in bytes
   localparam logic [2:0] LEN_WSTAT = 3'h2;
   localparam logic [2:0] LEN_WCFG  = 3'h3;
   localparam logic [2:0] LEN_ADDR  = 3'h4;
   localparam logic [2:0] LEN_PROG  = 3'h5;

   // reset values
   localparam logic [3:0] LEVEL_RST  = 4'h0;
   localparam logic       BOTTOM_RST = 1'b0;
   localparam logic       STATUS_WRITE_DISABLE_RST   = 1'b0;
   localparam logic       CUST_RST   = 1'b0;

   typedef enum logic [2:0] {
      CL_NONE, CL_RD_STATUS, CL_RD_CONFIG, CL_RD_SEC, CL_RD_ARRAY, CL_WRITE
   } sfp_class_e;

   typedef enum logic [2:0] {
      K_CHIP, K_SECTOR, K_BLOCK32, K_BLOCK64, K_PROGRAM
   } sfp_kind_e;

   typedef struct packed {
      logic        valid;
      sfp_kind_e   kind;
      logic        otp;
      logic [23:0] addr;
   } sfp_req_s;

   // sort an opcode into read, write or unknown
   function automatic sfp_class_e sfp_classify(input logic [7:0] op);
      case (op)
         OP_READ_STATUS:  return CL_RD_STATUS;
         OP_READ_CONFIG:  return CL_RD_CONFIG;
         OP_SEC_READ:     return CL_RD_SEC;
         OP_READ, OP_FAST_READ: return CL_RD_ARRAY;
         OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_WRITE_STATUS,
         OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SECTOR_ERASE,
         OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_PAGE_PROGRAM,
         OP_ENTER_OTP, OP_EXIT_OTP, OP_SEC_WRITE: return CL_WRITE;
         default:         return CL_NONE;
      endcase
   endfunction

   // one bit per 64KB block, set where protected
   function automatic logic [7:0] sfp_prot_mask(input logic [3:0] lvl,
                                                input logic       bot);
      case (lvl)
         4'h0:    return 8'h00;
         4'h1:    return bot ? 8'h01 : 8'h80;
         4'h2:    return bot ? 8'h03 : 8'hC0;
         4'h3:    return bot ? 8'h0F : 8'hF0;
         default: return 8'hFF;
      endcase
   endfunction
endpackage

// *** rtl/sfp_gate.sv ***
// protect gate: spi frame capture, command checks, otp and block protection
// Notes on behaviour
// - top selector: levels map to upper blocks
// - bottom selector: levels map to lower blocks
// - chip erase only when level is zero
// - otp halves split by address bit 9
// - security bit 0 shows factory lock
// - security write sets customer lock bit 1
// - locked otp half refuses any change
// - otp mode blocks main array access
// - unknown opcode: standby, output off
// - known opcode: active until chip select rises
// - sample on rising, shift on falling
// - serial modes 0 and 3 both work
// - reads may end after any bit
// - writes must end on byte boundary
// - busy device ignores array commands
// - data changes need write enable latch
// - protect pin guards level, not quad
// - protected blocks refuse program and erase
`timescale 1ns/1ps
`default_nettype none
module sfp_gate
   import sfp_pkg::*;
(
   input  wire logic     core_clk,                // core clock, 200 MHz
   input  wire logic     reset,                   // sync reset, high
   input  wire logic     sclk,                    // serial clock from host
   input  wire logic     cs_n,                    // chip select, low
   input  wire logic     si,                      // serial data in
   input  wire logic     write_protect_io2_i,     // protect pin, low
   output var  logic     so_o,                    // serial data out
   output var  logic     so_oe,                   // serial out enable
   input  wire logic     busy_i,                  // internal op running
   input  wire logic     quad_mode_i,             // four-wire mode
   input  wire logic     factory_lock_i,          // factory otp lock
   output var  sfp_pkg::sfp_req_s req_o,          // program/erase pulse
   output var  logic     cmd_reject_o,            // refused write pulse
   output var  logic [3:0] protect_level_bits_o,  // protect level
   output var  logic     bottom_protect_select_o, // bottom selector
   output var  logic     status_write_disable_o,  // status lock bit
   output var  logic     write_enable_latch_o,    // write enable latch
   output var  logic     hardware_protect_mode_o, // pin guards level
   output var  logic     otp_mode_o,              // in otp mode
   output var  logic [1:0] sec_reg_o,             // customer, factory
   output var  logic     array_open_o             // array may be used
);
   import sfp_pkg::*;

   // link side, rising edge state
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] cnt;
      logic [7:0] rx;
      logic       byte_tgl;
      logic       bit_tgl;
      logic       have_op;
      logic       standby;
      sfp_class_e cls;
   } sfp_rise_s;

   // link side, falling edge state
   typedef struct packed {
      logic [7:0] tx;
      logic       so;
      logic       oe;
   } sfp_fall_s;

   // core side state
   typedef struct packed {
      logic [3:0]  s1, s2, s3, f;  // 0 cs_n, 1 bit, 2 byte, 3 pin
      logic [2:0]  bitcnt;
      logic [2:0]  nbytes;
      logic [7:0]  op;
      logic [23:0] addr;
      logic [3:0]  level;
      logic        bottom;
      logic        status_write_disable;
      logic        write_enable_latch;
      logic        otp;
      logic        cust;
      logic        fact;
      logic        busy_seen;
      logic        hardware_protect_mode;
      logic        open;
      logic        reject;
      sfp_req_s    req;
   } sfp_core_s;

   sfp_rise_s rs_q, rs_d;
   sfp_fall_s fs_q, fs_d;
   sfp_core_s cs_q, cs_d;
   logic [7:0] sts_byte, cfg_byte, sec_byte;

   // bytes the host may read; held still by the core while cs_n is low, save fact, which follows factory_lock_i every cycle
   assign sts_byte = {cs_q.status_write_disable, 1'b0, cs_q.level, cs_q.write_enable_latch, cs_q.busy_seen};
   assign cfg_byte = {4'h0, cs_q.bottom, 3'h0};
   assign sec_byte = {6'h00, cs_q.cust, cs_q.fact};

   // rising edge: shift in, classify first byte
   always_comb begin
      rs_d = rs_q;
      if (!rs_q.standby) begin
         rs_d.sh = {rs_q.sh[6:0], si};
         rs_d.cnt = rs_q.cnt + 3'h1;
         rs_d.bit_tgl = ~rs_q.bit_tgl;
         if (rs_q.cnt == 3'h7) begin
            rs_d.rx = {rs_q.sh[6:0], si};
            rs_d.byte_tgl = ~rs_q.byte_tgl;
            if (!rs_q.have_op) begin
               rs_d.have_op = 1'b1;
               rs_d.cls = sfp_classify({rs_q.sh[6:0], si});
               rs_d.standby = (sfp_classify({rs_q.sh[6:0], si}) == CL_NONE);
            end
         end
      end
   end

   // chip select high clears the frame at once, even with sclk parked
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rs_q <= '0;
      end else begin
         rs_q <= rs_d;
      end
   end

   // falling edge: load a byte at each boundary, else shift
   always_comb begin
      fs_d = fs_q;
      if (rs_q.have_op && !rs_q.standby &&
          (rs_q.cls == CL_RD_STATUS || rs_q.cls == CL_RD_CONFIG ||
           rs_q.cls == CL_RD_SEC)) begin
         if (rs_q.cnt == 3'h0) begin
            fs_d.oe = 1'b1;
            unique case (rs_q.cls)
               CL_RD_CONFIG: fs_d.tx = cfg_byte;
               CL_RD_SEC:    fs_d.tx = sec_byte;
               default:      fs_d.tx = sts_byte;
            endcase
            fs_d.so = fs_d.tx[7];
            fs_d.tx = {fs_d.tx[6:0], 1'b0};
         end else begin
            fs_d.so = fs_q.tx[7];
            fs_d.tx = {fs_q.tx[6:0], 1'b0};
         end
      end
   end

   // mode 3 idle-high clock gives a falling edge before any data: harmless
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fs_q <= '0;
      end else begin
         fs_q <= fs_d;
      end
   end

   assign so_o  = fs_q.so;
   assign so_oe = fs_q.oe;

   // core: synchronise, count, decide at chip select release
   always_comb begin
      logic [3:0] diff;
      logic [3:0] ev;
      logic [7:0] mask;
      logic       locked;
      logic       ok;
      diff = 4'h0;
      ev = 4'h0;
      mask = 8'h00;
      locked = 1'b0;
      ok = 1'b0;
      cs_d = cs_q;
      cs_d.req.valid = 1'b0;
      cs_d.reject = 1'b0;
      cs_d.s1 = {write_protect_io2_i, rs_q.byte_tgl, rs_q.bit_tgl, cs_n};
      cs_d.s2 = cs_q.s1;
      cs_d.s3 = cs_q.s2;
      // a change counts once stages two and three agree
      diff = cs_q.s2 ^ cs_q.s3;
      cs_d.f = (cs_q.s2 & ~diff) | (cs_q.f & diff);
      ev = cs_d.f ^ cs_q.f;
      cs_d.fact = factory_lock_i;
      cs_d.hardware_protect_mode = cs_q.status_write_disable & ~cs_q.f[3] & ~quad_mode_i;
      cs_d.open = ~cs_q.otp & ~busy_i;
      if (cs_q.f[0]) begin
         cs_d.busy_seen = busy_i;
      end
      mask = sfp_prot_mask(cs_q.level, cs_q.bottom);
      // frame start
      if (ev[0] && !cs_d.f[0]) begin
         cs_d.bitcnt = 3'h0;
         cs_d.nbytes = 3'h0;
      end
      if (ev[1] && !cs_q.f[0]) begin
         cs_d.bitcnt = cs_q.bitcnt + 3'h1;
      end
      if (ev[2] && !cs_q.f[0]) begin
         unique case (cs_q.nbytes)
            3'h0:    cs_d.op = rs_q.rx;
            3'h1:    cs_d.addr[23:16] = rs_q.rx;
            3'h2:    cs_d.addr[15:8] = rs_q.rx;
            3'h3:    cs_d.addr[7:0] = rs_q.rx;
            default: cs_d.addr = cs_q.addr;
         endcase
         if (cs_q.nbytes != 3'h7) begin
            cs_d.nbytes = cs_q.nbytes + 3'h1;
         end
      end
      // frame end: only write commands act here
      if (ev[0] && cs_d.f[0] && cs_q.nbytes != 3'h0 &&
          sfp_classify(cs_q.op) == CL_WRITE) begin
         ok = (cs_q.bitcnt == 3'h0) && !busy_i;
         cs_d.req.addr = cs_q.addr;
         cs_d.req.otp = 1'b0;
         cs_d.req.kind = K_PROGRAM;
         if (ok) begin
            case (cs_q.op)
               OP_WRITE_ENABLE: cs_d.write_enable_latch = 1'b1;
               OP_WRITE_DISABLE: cs_d.write_enable_latch = 1'b0;
               OP_ENTER_OTP: cs_d.otp = 1'b1;
               OP_EXIT_OTP: cs_d.otp = 1'b0;
               OP_WRITE_STATUS: begin
                  ok = cs_q.write_enable_latch && cs_q.nbytes >= LEN_WSTAT;
                  if (ok && !cs_q.hardware_protect_mode) begin
                     cs_d.level = cs_q.addr[STS_LEVEL_LSB+16 +: 4];
                     cs_d.status_write_disable = cs_q.addr[STS_STATUS_WRITE_DISABLE_POS+16];
                  end
                  if (ok && cs_q.nbytes >= LEN_WCFG) begin
                     cs_d.bottom = cs_q.addr[CFG_BOTTOM_POS+8];
                  end
               end
               OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                  ok = cs_q.write_enable_latch && cs_q.level == 4'h0 && !cs_q.otp;
                  cs_d.req.kind = K_CHIP;
               end
               OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: begin
                  // no erase inside otp space
                  ok = cs_q.write_enable_latch && cs_q.nbytes >= LEN_ADDR && !cs_q.otp &&
                       !mask[cs_q.addr[BLOCK_LSB +: 3]];
                  cs_d.req.kind = (cs_q.op == OP_SECTOR_ERASE) ? K_SECTOR :
                     (cs_q.op == OP_BLOCK32_ERASE) ? K_BLOCK32 : K_BLOCK64;
               end
               OP_PAGE_PROGRAM: begin
                  // upper otp half is the factory one
                  locked = cs_q.addr[OTP_HALF_POS] ? cs_q.fact
                                                   : cs_q.cust;
                  ok = cs_q.write_enable_latch && cs_q.nbytes >= LEN_PROG &&
                       (cs_q.otp ? !locked
                                 : !mask[cs_q.addr[BLOCK_LSB +: 3]]);
                  cs_d.req.otp = cs_q.otp;
               end
               OP_SEC_WRITE: begin
                  ok = cs_q.write_enable_latch;
                  if (ok) begin
                     cs_d.cust = 1'b1;
                  end
               end
               default: ok = 1'b0;
            endcase
         end
         // any accepted data-changing command uses up the latch
         if (cs_q.op != OP_WRITE_ENABLE && cs_q.op != OP_ENTER_OTP &&
             cs_q.op != OP_EXIT_OTP && ok) begin
            cs_d.write_enable_latch = 1'b0;
         end
         cs_d.req.valid = ok && (cs_q.op == OP_CHIP_ERASE_A ||
            cs_q.op == OP_CHIP_ERASE_B || cs_q.op == OP_SECTOR_ERASE ||
            cs_q.op == OP_BLOCK32_ERASE || cs_q.op == OP_BLOCK64_ERASE ||
            cs_q.op == OP_PAGE_PROGRAM);
         cs_d.reject = !ok;
      end
   end

   // core register; sync stages start high so no false edge at release
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cs_q <= '0;
         cs_q.s1 <= 4'hF;
         cs_q.s2 <= 4'hF;
         cs_q.s3 <= 4'hF;
         cs_q.f <= 4'hF;
         cs_q.level <= LEVEL_RST;
         cs_q.bottom <= BOTTOM_RST;
         cs_q.status_write_disable <= STATUS_WRITE_DISABLE_RST;
         cs_q.cust <= CUST_RST;
      end else begin
         cs_q <= cs_d;
      end
   end

   assign req_o = cs_q.req;
   assign cmd_reject_o = cs_q.reject;
   assign protect_level_bits_o = cs_q.level;
   assign bottom_protect_select_o = cs_q.bottom;
   assign status_write_disable_o = cs_q.status_write_disable;
   assign write_enable_latch_o = cs_q.write_enable_latch;
   assign hardware_protect_mode_o = cs_q.hardware_protect_mode;
   assign otp_mode_o = cs_q.otp;
   assign sec_reg_o = {cs_q.cust, cs_q.fact};
   assign array_open_o = cs_q.open;

   // checks on the core side, plus one on the falling sclk edge
   AST_CHIP_ERASE_LEVEL: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.req.valid && cs_q.req.kind == K_CHIP |-> $past(cs_q.level) == 4'h0)
      else $error("chip erase issued with nonzero level");
   AST_BLOCK_GUARD: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.req.valid && !cs_q.req.otp && cs_q.req.kind != K_CHIP |->
      ((sfp_prot_mask($past(cs_q.level), $past(cs_q.bottom)) >>
        cs_q.req.addr[BLOCK_LSB +: 3]) & 8'h01) == 8'h00)
      else $error("request hits a protected block");
   AST_OTP_LOCKED: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.req.valid && cs_q.req.otp |->
      !(cs_q.req.addr[9] ? $past(cs_q.fact) : $past(cs_q.cust)))
      else $error("program into locked otp half");
   AST_OTP_CLOSES_ARRAY: assert property (
      @(posedge core_clk) disable iff (reset)
      $rose(cs_q.otp) |=> !cs_q.open)
      else $error("array open while in otp mode");
   AST_BUSY_IGNORED: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.req.valid |-> !$past(busy_i))
      else $error("request accepted while busy");
   AST_LATCH_USED: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.req.valid |-> $past(cs_q.write_enable_latch) && !cs_q.write_enable_latch)
      else $error("request without write enable latch");
   AST_CUST_STICKY: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.cust |=> cs_q.cust [*3])
      else $error("customer lock fell");
   AST_PIN_GUARD: assert property (
      @(posedge core_clk) disable iff (reset)
      cs_q.hardware_protect_mode && cs_d.hardware_protect_mode |=> $stable(cs_q.level) && $stable(cs_q.status_write_disable))
      else $error("level changed under pin guard");
   AST_STANDBY_QUIET: assert property (
      @(negedge sclk) disable iff (cs_n)
      rs_q.standby |-> !fs_d.oe)
      else $error("output driven in standby");

   CV_CHIP_ERASE: cover property (@(posedge core_clk) disable iff (reset)
      cs_q.req.valid && cs_q.req.kind == K_CHIP);
   CV_OTP_PROGRAM: cover property (@(posedge core_clk) disable iff (reset)
      cs_q.req.valid && cs_q.req.otp);
   CV_REJECT: cover property (@(posedge core_clk) disable iff (reset)
      cs_q.reject);
endmodule
`default_nettype wire

// *** test/sfp_host.sv ***
// host serial controller model: chip select, link clock, data out
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
   input  wire logic so_o,  // device data out
   input  wire logic so_oe, // device drives so
   output var  logic sclk,  // link clock, still between frames
   output var  logic cs_n,  // chip select, low
   output var  logic si     // host data out
);
   // idle: deselected, clock parked
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // one frame msb first; m=1 is mode 3 (clock idles high)
   task automatic frame(input logic [39:0] d, input int n, input logic m,
                        output logic [15:0] rd, output logic oe);
      rd = 16'h0000;
      oe = 1'b0;
      sclk = m;
      #20 cs_n = 1'b0;
      #20;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         si = d[39-i];
         #40 sclk = 1'b1;
         // a released line reads as the inverse of its last bit
         if (i >= 8) rd = {rd[14:0], so_oe ? so_o : ~rd[0]};
         oe = oe | so_oe;
         #40;
      end
      sclk = m;
      #20 cs_n = 1'b1;
      si = ~si;
      #60;
   endtask
endmodule
`default_nettype wire

// *** test/tb_serial_flash_protect_gate.sv ***
// self-checking bench of the protect gate with a host link model
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_protect_gate;
   import sfp_pkg::*;
   typedef struct packed {
      logic     rej;
      sfp_req_s req;
   } sfp_exp_s;
   logic        core_clk, reset, busy, quad, fact, wp_n, sclk, cs_n, si;
   logic        so, so_oe, rej, hardware_protect_mode, status_write_disable, write_enable_latch, otp, aopen, bot, oe, b;
   sfp_req_s    req;
   logic [3:0]  lvl, l;
   logic [1:0]  sec;
   logic [15:0] rd;
   logic [23:0] a;
   logic [7:0]  m, eop;
   sfp_kind_e   ke;
   sfp_exp_s    expq[$];
   int          n_mismatch = 0;
   int          compares = 0;

   sfp_gate u_dut (.core_clk(core_clk), .reset(reset), .sclk(sclk),
      .cs_n(cs_n), .si(si), .write_protect_io2_i(wp_n), .so_o(so),
      .so_oe(so_oe), .busy_i(busy), .quad_mode_i(quad),
      .factory_lock_i(fact), .req_o(req), .cmd_reject_o(rej),
      .protect_level_bits_o(lvl), .bottom_protect_select_o(bot),
      .status_write_disable_o(status_write_disable), .write_enable_latch_o(write_enable_latch),
      .hardware_protect_mode_o(hardware_protect_mode), .otp_mode_o(otp), .sec_reg_o(sec),
      .array_open_o(aopen));
   sfp_host u_host (.so_o(so), .so_oe(so_oe), .sclk(sclk), .cs_n(cs_n),
      .si(si));

   // 200 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic conclude();
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [23:0] e,
                      input logic [23:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // rejects carry no request; chip erase carries no address
   task automatic cmp_evt(input sfp_exp_s e, input sfp_exp_s g);
      if (e.rej) g.req = e.req;
      else if (e.req.kind == K_CHIP) g.req.addr = e.req.addr;
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error event expected %h seen %h", e, g);
      end
   endtask

   function automatic void ex(input logic r, input sfp_kind_e k,
                              input logic o, input logic [23:0] ad);
      expq.push_back({r, 1'b1, k, o, ad});
   endfunction

   // own decode of the protected block mask
   function automatic logic [7:0] emask(input logic [3:0] lv, input logic bt);
      logic [3:0] c;
      logic [7:0] low;
      if (lv == 4'h0) return 8'h00;
      if (lv > 4'h3) return 8'hFF;
      c = 4'h1 << (lv - 4'h1);
      low = 8'((9'h001 << c) - 9'h001);
      return bt ? low : 8'(low << (4'h8 - c));
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // random serial mode per frame, odd offset keeps edges off core edges
   task automatic send(input logic [39:0] d, input int n);
      #1.3;
      u_host.frame(d, n, 1'($urandom), rd, oe);
      tick(10);
   endtask

   task automatic wen();
      send({OP_WRITE_ENABLE, 32'h0}, 8);
   endtask

   task automatic wsr(input logic s7, input logic [3:0] lv, input logic bt);
      wen();
      send({OP_WRITE_STATUS, s7, 1'b0, lv, 2'b00, 4'h0, bt, 3'h0, 16'h0}, 24);
   endtask

   // pair every pulse with the oldest noted expectation
   always @(negedge core_clk) begin
      if (!reset && (req.valid === 1'b1 || rej === 1'b1)) begin
         if (expq.size() == 0) cmp("event", 24'h0, 24'h1);
         else cmp_evt(expq.pop_front(), {rej, req});
      end
   end

   // watchdog
   initial begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      reset = 1'b1;
      busy = 1'b0;
      quad = 1'b0;
      fact = 1'b1;
      wp_n = 1'b1;
      void'($urandom(82274));
      tick(2);
      cmp("reset", 24'h0, {12'h0, lvl, bot, status_write_disable, write_enable_latch, hardware_protect_mode, otp, sec, aopen});
      reset <= 1'b0;
      tick(2);
      send({OP_READ_STATUS, 32'h0}, 24);
      cmp("status", 24'h0, {8'h0, rd});
      cmp("drive", 24'h1, {23'h0, oe});
      for (int k = 0; k < 12; k++) begin
         l = (k % 6 == 5) ? 4'($urandom_range(15, 5)) : 4'(k % 6);
         b = (k >= 6);
         a = {5'h0, 3'($urandom), 16'($urandom)};
         wsr(1'b0, l, b);
         cmp("level", {19'h0, b, l}, {19'h0, bot, lvl});
         wen();
         ke = sfp_kind_e'(3'($urandom_range(3, 1)));
         eop = (ke == K_SECTOR) ? OP_SECTOR_ERASE :
               (ke == K_BLOCK32) ? OP_BLOCK32_ERASE : OP_BLOCK64_ERASE;
         m = emask(l, b);
         ex(m[a[18:16]], ke, 1'b0, a);
         send({eop, a, 8'h0}, 32);
      end
      send({OP_READ_CONFIG, 32'h0}, 16);
      cmp("config", 24'h08, {16'h0, rd[7:0]});
      send({OP_READ, 24'h012345, 8'h0}, 40);
      cmp("drive", 24'h0, {23'h0, oe});
      wen();
      ex(1'b1, K_CHIP, 1'b0, 24'h0);
      send({OP_CHIP_ERASE_A, 32'h0}, 8);
      wsr(1'b0, 4'h0, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wen();
         ex(1'b0, K_CHIP, 1'b0, 24'h0);
         send({k ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 32'h0}, 8);
      end
      wen();
      ex(1'b1, K_CHIP, 1'b0, 24'h0);
      send({OP_CHIP_ERASE_A, 32'h0}, 12);
      send({OP_READ_STATUS, 32'h0}, 11);
      send({OP_WRITE_DISABLE, 32'h0}, 8);
      cmp("latch", 24'h0, {23'h0, write_enable_latch});
      ex(1'b1, K_BLOCK64, 1'b0, 24'h0);
      send({OP_BLOCK64_ERASE, 24'h010000, 8'h0}, 32);
      wen();
      @(posedge core_clk) busy <= 1'b1;
      tick(3);
      cmp("open", 24'h0, {23'h0, aopen});
      send({OP_READ_STATUS, 32'h0}, 24);
      cmp("status", 24'h0303, {8'h0, rd});
      ex(1'b1, K_BLOCK64, 1'b0, 24'h0);
      send({OP_BLOCK64_ERASE, 24'h010000, 8'h0}, 32);
      @(posedge core_clk) busy <= 1'b0;
      send({8'hFF, 32'hFFFFFFFF}, 24);
      cmp("drive", 24'h0, {23'h0, oe});
      send({OP_SEC_READ, 32'h0}, 16);
      cmp("security", 24'h01, {16'h0, rd[7:0]});
      send({OP_ENTER_OTP, 32'h0}, 8);
      cmp("otp", 24'h2, {22'h0, otp, aopen});
      wen();
      ex(1'b0, K_PROGRAM, 1'b1, 24'h000100);
      send({OP_PAGE_PROGRAM, 24'h000100, 8'h5A}, 40);
      wen();
      ex(1'b1, K_PROGRAM, 1'b1, 24'h0);
      send({OP_PAGE_PROGRAM, 24'h000300, 8'hA5}, 40);
      wen();
      ex(1'b1, K_SECTOR, 1'b1, 24'h0);
      send({OP_SECTOR_ERASE, 24'h000100, 8'h0}, 32);
      wen();
      send({OP_SEC_WRITE, 32'h0}, 8);
      cmp("security", 24'h3, {22'h0, sec});
      wen();
      ex(1'b1, K_PROGRAM, 1'b1, 24'h0);
      send({OP_PAGE_PROGRAM, 24'h000100, 8'h5A}, 40);
      send({OP_EXIT_OTP, 32'h0}, 8);
      cmp("otp", 24'h1, {22'h0, otp, aopen});
      wen();
      ex(1'b0, K_PROGRAM, 1'b0, 24'h070000);
      send({OP_PAGE_PROGRAM, 24'h070000, 8'h3C}, 40);
      wsr(1'b1, 4'h1, 1'b0);
      cmp("level", 24'h11, {19'h0, status_write_disable, lvl});
      wen();
      ex(1'b1, K_PROGRAM, 1'b0, 24'h0);
      send({OP_PAGE_PROGRAM, 24'h07FF00, 8'h3C}, 40);
      @(posedge core_clk) wp_n <= 1'b0;
      tick(8);
      cmp("guard", 24'h1, {23'h0, hardware_protect_mode});
      wsr(1'b0, 4'h2, 1'b0);
      cmp("level", 24'h11, {19'h0, status_write_disable, lvl});
      @(posedge core_clk) quad <= 1'b1;
      tick(8);
      cmp("guard", 24'h0, {23'h0, hardware_protect_mode});
      wsr(1'b0, 4'h2, 1'b0);
      cmp("level", 24'h02, {19'h0, status_write_disable, lvl});
      cmp("pending", 24'h0, 24'(expq.size()));
      conclude();
   end
endmodule
`default_nettype wire
